// File: cip_defs.svh
// Contract
// - rotation value Y gives vector Y+1 top normal priority, then ascending vector numbers.
// - normal order wraps past the last vector; reset and nonmaskable always rank first.
// - round robin writes each acknowledged normal vector into the rotation register.
// - round robin makes the last acknowledged normal vector lowest for the next choice.
// - round robin enable 1 turns rotation on; 0 keeps fixed order.
// - compact table: nonmaskable at 1, high at 2, all normal at 3.
// - protected bit writes without a valid unlock are ignored, bits unchanged.
// - round robin enable bit is writable at any time, no unlock needed.
// - location bit 1 puts the table at boot start, 0 right after boot.
// - location bit is ignored when the whole flash is boot section.
// - system reset starts execution at address zero whatever the location bit.
// - nonmaskable executing flag set during its handler, cleared by its return.
// - high executing flag set while its handler runs or is preempted.
// - normal executing flag set while its handler runs or is preempted.
// - each return restores exactly the level active before that handler began.
// - high priority vector register names the high vector; zero means none.
// - a high request preempts a normal handler, which resumes after its return.
// - nothing preempts a nonmaskable handler; lowest nonmaskable vector wins ties.
// - nonmaskable requests ignore the global enable and never change it.
`ifndef CIP_DEFS_SVH
`define CIP_DEFS_SVH
`define CIP_NUM_VEC 32
`define CIP_VEC_W 5
`define CIP_OFS_CONTROL 8'h00
`define CIP_OFS_LEVEL_STATE 8'h01
`define CIP_OFS_ROTATION 8'h02
`define CIP_OFS_HIGH_VECTOR 8'h03
`define CIP_BIT_LOCATION 6
`define CIP_BIT_COMPACT 5
`define CIP_BIT_ROUND_ROBIN 0
`define CIP_BIT_NM_EXEC 7
`define CIP_BIT_HIGH_EXEC 1
`define CIP_BIT_NORMAL_EXEC 0
`define CIP_REG_RESET 8'h00
`define CIP_NONMASKABLE_MASK 32'h0000_0002
`define CIP_USABLE_MASK 32'hffff_fffe
`define CIP_UNLOCK_KEY 8'h5a
`define CIP_UNLOCK_WINDOW 3'h4
`define CIP_COMPACT_NM_VEC 8'h01
`define CIP_COMPACT_HIGH_VEC 8'h02
`define CIP_COMPACT_NORMAL_VEC 8'h03
`define CIP_VEC_SHIFT 1
`define CIP_RESET_PC 16'h0000
`endif

// File: cip_pkg.sv
package cip_pkg;
    // one-hot priority level of an offered or accepted request
    typedef enum logic [2:0] {
        CIP_KIND_NORMAL = 3'b001,
        CIP_KIND_HIGH = 3'b010,
        CIP_KIND_NM = 3'b100
    } cip_kind_t;

    // what the controller offers the core
    typedef struct packed {
        logic valid;
        cip_kind_t kind;
        logic [7:0] vector;
        logic [15:0] address;
    } cip_offer_t;
endpackage : cip_pkg

// File: cip_core.sv
// Chosen here: the strobed register port.
`timescale 1ns/1ps
`include "cip_defs.svh"

module cip_core (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic guard_key_wr,
    input wire logic [7:0] guard_key,
    input wire logic instr_retire,
    input wire logic [31:0] irq_req,
    input wire logic global_ie,
    input wire logic core_ack,
    input wire logic return_from_interrupt,
    input wire logic [15:0] boot_end,
    input wire logic boot_all,
    output cip_pkg::cip_offer_t irq_offer,
    output logic [15:0] reset_pc
);
    import cip_pkg::*;

    // nonmaskable vectors as a named constant, since a bare literal cannot be indexed;
    // the high vector decode uses it to refuse a nonmaskable vector
    localparam logic [31:0] nm_vector_mask = `CIP_NONMASKABLE_MASK;

    // ********************************************************
    // state
    // ********************************************************
    logic location_select;
    logic compact_table_enable;
    logic round_robin_enable;
    logic [7:0] normal_priority_rotation;
    logic [7:0] high_priority_vector;
    logic nonmaskable_executing;
    logic high_level_executing;
    logic normal_level_executing;
    logic [2:0] unlock_count;
    logic [4:0] accepted_vec;
    cip_kind_t accepted_kind;

    // ********************************************************
    // helper functions
    // ********************************************************

    // first set request walking upward from start, wrapping; bit 5 is found
    function automatic logic [5:0] first_from(
        input logic [31:0] req,
        input logic [4:0] start
    );
        logic [5:0] res;
        logic [4:0] idx;
        res = 6'h00;
        // walk downward so the entry nearest to start is the one kept
        for (int i = `CIP_NUM_VEC - 1; i >= 0; i--) begin
            idx = start + 5'(i);
            if (req[idx]) begin
                res = {1'b1, idx};
            end
        end
        return res;
    endfunction : first_from

    // table word address of a delivered vector
    function automatic logic [15:0] vector_address(
        input logic [15:0] base,
        input logic [7:0] vec
    );
        return base + ({8'h00, vec} << `CIP_VEC_SHIFT);
    endfunction : vector_address

    // a write strobe aimed at one offset; every writable register decodes this way,
    // so a new register cannot miss the compare
    function automatic logic write_hit(
        input logic wr,
        input logic [7:0] addr,
        input logic [7:0] offset
    );
        return wr && (addr == offset);
    endfunction : write_hit

    // ********************************************************
    // request classification
    // ********************************************************
    logic high_valid;
    logic [31:0] high_onehot;
    logic [31:0] nm_req;
    logic [31:0] normal_req;
    logic [5:0] nm_pick;
    logic [5:0] normal_pick;
    logic [4:0] rotation_start;
    logic nm_allowed;
    logic high_allowed;
    logic normal_allowed;

    // a zero or out-of-range high vector selects nothing; a nonmaskable
    // vector cannot be demoted to the high level
    assign high_valid = (high_priority_vector != 8'h00)
        && (high_priority_vector < 8'(`CIP_NUM_VEC))
        && !nm_vector_mask[high_priority_vector[4:0]];
    assign high_onehot = high_valid ? (32'h1 << high_priority_vector[4:0]) : 32'h0;

    // vector 0 is reset and never arbitrated here
    assign nm_req = irq_req & `CIP_NONMASKABLE_MASK;
    assign normal_req = irq_req & `CIP_USABLE_MASK & ~`CIP_NONMASKABLE_MASK & ~high_onehot;

    // lowest nonmaskable vector wins a tie
    assign nm_pick = first_from(nm_req, 5'h00);

    // start one past the rotation value and wrap over the top vector;
    // with the register at zero this is plain lowest-address-first
    assign rotation_start = normal_priority_rotation[4:0] + 5'h01;
    assign normal_pick = first_from(normal_req, rotation_start);

    // ********************************************************
    // preemption rules
    // ********************************************************

    // a running nonmaskable handler blocks everything, and nonmaskable
    // requests do not look at the global enable at all
    assign nm_allowed = !nonmaskable_executing;
    // high preempts normal but not itself
    assign high_allowed = global_ie && !nonmaskable_executing && !high_level_executing;
    assign normal_allowed = global_ie && !nonmaskable_executing && !high_level_executing
        && !normal_level_executing;

    // ********************************************************
    // winner selection
    // ********************************************************
    logic cand_valid;
    cip_kind_t cand_kind;
    logic [4:0] cand_vec;
    logic [7:0] cand_delivered;
    logic [15:0] table_base;

    // strict order: nonmaskable, high vector, then normal winner
    always_comb begin
        cand_valid = 1'b0;
        cand_kind = CIP_KIND_NORMAL;
        cand_vec = 5'h00;
        if (nm_allowed && nm_pick[5]) begin
            cand_valid = 1'b1;
            cand_kind = CIP_KIND_NM;
            cand_vec = nm_pick[4:0];
        end else if (high_allowed && high_valid && irq_req[high_priority_vector[4:0]]) begin
            cand_valid = 1'b1;
            cand_kind = CIP_KIND_HIGH;
            cand_vec = high_priority_vector[4:0];
        end else if (normal_allowed && normal_pick[5]) begin
            cand_valid = 1'b1;
            cand_kind = CIP_KIND_NORMAL;
            cand_vec = normal_pick[4:0];
        end
    end

    // compact table folds each level onto one fixed vector
    always_comb begin
        cand_delivered = {3'h0, cand_vec};
        if (compact_table_enable) begin
            unique case (cand_kind)
                CIP_KIND_NM: cand_delivered = `CIP_COMPACT_NM_VEC;
                CIP_KIND_HIGH: cand_delivered = `CIP_COMPACT_HIGH_VEC;
                CIP_KIND_NORMAL: cand_delivered = `CIP_COMPACT_NORMAL_VEC;
            endcase
        end
    end

    // table base; an all-boot flash has no "after boot" so the bit is moot
    assign table_base = (boot_all || location_select) ? 16'h0000 : boot_end;

    // reset entry never depends on the location bit
    assign reset_pc = `CIP_RESET_PC;

    // ********************************************************
    // offer to the core
    // ********************************************************

    // the offer is registered; it drops for one cycle after an accept so the
    // next choice sees the updated level flags and rotation
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_offer <= '0;
        end else if (core_ack || return_from_interrupt) begin
            irq_offer.valid <= 1'b0;
        end else begin
            irq_offer.valid <= cand_valid;
            irq_offer.kind <= cand_kind;
            irq_offer.vector <= cand_delivered;
            irq_offer.address <= vector_address(table_base, cand_delivered);
        end
    end

    // raw vector and level behind the current offer
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            accepted_vec <= 5'h00;
            accepted_kind <= CIP_KIND_NORMAL;
        end else if (!core_ack) begin
            accepted_vec <= cand_vec;
            accepted_kind <= cand_kind;
        end
    end

    logic take;
    assign take = core_ack && irq_offer.valid;

    // accepted level, decoded once for the level flags and the rotation update;
    // accepted_kind, not the live candidate, names what the core took
    logic take_nm;
    logic take_high;
    logic take_normal;
    assign take_nm = take && (accepted_kind == CIP_KIND_NM);
    assign take_high = take && (accepted_kind == CIP_KIND_HIGH);
    assign take_normal = take && (accepted_kind == CIP_KIND_NORMAL);

    // a return ends only the highest level in flight; the lower ones were preempted,
    // so clearing one flag drops back to the level held before that entry.
    // a stray return with no flag set changes nothing
    logic end_nm;
    logic end_high;
    logic end_normal;
    assign end_nm = return_from_interrupt && nonmaskable_executing;
    assign end_high = return_from_interrupt && !nonmaskable_executing && high_level_executing;
    assign end_normal = return_from_interrupt && !nonmaskable_executing
        && !high_level_executing && normal_level_executing;

    // ********************************************************
    // executing level flags
    // ********************************************************

    // entering sets the level's flag; lower flags stay set while preempted.
    // a return clears only the highest set flag, which drops the controller
    // back to exactly the level it was at before that handler began.
    // nothing here touches the peripheral request flags.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            nonmaskable_executing <= 1'b0;
        end else if (take_nm) begin
            nonmaskable_executing <= 1'b1;
        end else if (end_nm) begin
            nonmaskable_executing <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            high_level_executing <= 1'b0;
        end else if (take_high) begin
            high_level_executing <= 1'b1;
        end else if (end_high) begin
            high_level_executing <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            normal_level_executing <= 1'b0;
        end else if (take_normal) begin
            normal_level_executing <= 1'b1;
        end else if (end_normal) begin
            normal_level_executing <= 1'b0;
        end
    end

    // ********************************************************
    // change protection window
    // ********************************************************
    logic wr_control;
    logic unlocked;

    assign wr_control = write_hit(reg_wr, reg_addr, `CIP_OFS_CONTROL);
    assign unlocked = (unlock_count != 3'h0);

    // the key opens a window of four retired instructions; the protected
    // write itself closes it so one key buys one write
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            unlock_count <= 3'h0;
        end else if (guard_key_wr && guard_key == `CIP_UNLOCK_KEY) begin
            unlock_count <= `CIP_UNLOCK_WINDOW;
        end else if (wr_control && unlocked) begin
            unlock_count <= 3'h0;
        end else if (instr_retire && unlocked) begin
            unlock_count <= unlock_count - 3'h1;
        end
    end

    // ********************************************************
    // register writes
    // ********************************************************

    // protected bits only move inside an open window
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            location_select <= 1'b0;
            compact_table_enable <= 1'b0;
        end else if (wr_control && unlocked) begin
            location_select <= reg_wdata[`CIP_BIT_LOCATION];
            compact_table_enable <= reg_wdata[`CIP_BIT_COMPACT];
        end
    end

    // round robin enable is never guarded
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            round_robin_enable <= 1'b0;
        end else if (wr_control) begin
            round_robin_enable <= reg_wdata[`CIP_BIT_ROUND_ROBIN];
        end
    end

    // an accepted normal vector in round robin mode beats a software write
    // in the same cycle, so the fairness record is never lost;
    // in fixed mode the rotation belongs to software alone
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            normal_priority_rotation <= `CIP_REG_RESET;
        end else if (take_normal && round_robin_enable) begin
            normal_priority_rotation <= {3'h0, accepted_vec};
        end else if (write_hit(reg_wr, reg_addr, `CIP_OFS_ROTATION)) begin
            normal_priority_rotation <= reg_wdata;
        end
    end

    // any value is stored; the decode above decides whether it selects a vector
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            high_priority_vector <= `CIP_REG_RESET;
        end else if (write_hit(reg_wr, reg_addr, `CIP_OFS_HIGH_VECTOR)) begin
            high_priority_vector <= reg_wdata;
        end
    end

    // ********************************************************
    // register reads
    // ********************************************************
    logic [7:0] next_rdata;

    // unused bits and unmapped offsets read zero
    always_comb begin
        next_rdata = 8'h00;
        unique case (reg_addr)
            `CIP_OFS_CONTROL: begin
                next_rdata[`CIP_BIT_LOCATION] = location_select;
                next_rdata[`CIP_BIT_COMPACT] = compact_table_enable;
                next_rdata[`CIP_BIT_ROUND_ROBIN] = round_robin_enable;
            end
            `CIP_OFS_LEVEL_STATE: begin
                next_rdata[`CIP_BIT_NM_EXEC] = nonmaskable_executing;
                next_rdata[`CIP_BIT_HIGH_EXEC] = high_level_executing;
                next_rdata[`CIP_BIT_NORMAL_EXEC] = normal_level_executing;
            end
            `CIP_OFS_ROTATION: next_rdata = normal_priority_rotation;
            `CIP_OFS_HIGH_VECTOR: next_rdata = high_priority_vector;
            default: next_rdata = 8'h00;
        endcase
    end

    // data stand only in the cycle after the read strobe
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= next_rdata;
        end else begin
            reg_rdata <= 8'h00;
        end
    end
endmodule : cip_core

// File: cip_chk.sv
`timescale 1ns/1ps
// ****************************************
// offer and register port checker
// ****************************************
module cip_chk (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic [31:0] irq_req,
    input wire logic global_ie,
    input wire logic core_ack,
    input wire logic boot_all,
    input wire cip_pkg::cip_offer_t irq_offer,
    input wire logic [15:0] reset_pc
);
    import cip_pkg::*;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    // a read request, answered in the following cycle
    sequence s_rd(logic [7:0] a);
        reg_rd && reg_addr == a;
    endsequence
    // the core taking a standing offer
    sequence s_take;
        core_ack && irq_offer.valid;
    endsequence

    chk_ctrl_unused: assert property (s_rd(8'h00) |=> (reg_rdata & 8'h9e) == 8'h00)
        else $error("control unused bits not zero");
    chk_status_unused: assert property (s_rd(8'h01) |=> (reg_rdata & 8'h7c) == 8'h00)
        else $error("status unused bits not zero");
    chk_unmapped_zero: assert property (reg_rd && reg_addr > 8'h03 |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    chk_reset_pc: assert property (reset_pc == 16'h0000)
        else $error("reset start address not zero");
    chk_one_winner: assert property (irq_offer.valid |-> $onehot(irq_offer.kind))
        else $error("offer kind not one level");
    chk_offer_cause: assert property (irq_offer.valid |-> $past(|irq_req[31:1]))
        else $error("offer without request");
    chk_take_drop: assert property (s_take |=> !irq_offer.valid)
        else $error("offer stands after accept");
    chk_nm_vector: assert property (irq_offer.valid && irq_offer.kind == CIP_KIND_NM
        |-> irq_offer.vector == 8'h01) else $error("nonmaskable vector wrong");
    chk_whole_boot: assert property (irq_offer.valid && $past(boot_all)
        |-> irq_offer.address == {7'h00, irq_offer.vector, 1'b0}) else $error("base not zero");
    chk_masked_ie: assert property (irq_offer.valid && irq_offer.kind != CIP_KIND_NM
        |-> $past(global_ie)) else $error("maskable offer with enable low");
endmodule : cip_chk

bind cip_core cip_chk chk_i (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq_req(irq_req), .global_ie(global_ie),
    .core_ack(core_ack), .boot_all(boot_all), .irq_offer(irq_offer), .reset_pc(reset_pc));

// File: cip_core_model.sv
`timescale 1ns/1ps
// ****************************************
// processor core model
// ****************************************
module cip_core_model (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire cip_pkg::cip_offer_t irq_offer,
    input wire logic [3:0] ack_delay,
    output logic core_ack,
    output logic [7:0] n_taken,
    output logic [7:0] last_vec,
    output logic [2:0] last_kind,
    output logic [15:0] last_addr
);
    import cip_pkg::*;
    logic [3:0] wait_cnt;

    // accept after a set wait; request lines stay with the peripherals, never cleared here
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            core_ack <= 1'b0;
            wait_cnt <= 4'h0;
            n_taken <= 8'h00;
            last_vec <= 8'h00;
            last_kind <= 3'h0;
            last_addr <= 16'h0000;
        end else if (core_ack) begin
            // offer captured on the edge that samples the accept
            core_ack <= 1'b0;
            wait_cnt <= 4'h0;
            if (irq_offer.valid) begin
                n_taken <= n_taken + 8'h01;
                last_vec <= irq_offer.vector;
                last_kind <= irq_offer.kind;
                last_addr <= irq_offer.address;
            end
        end else if (irq_offer.valid && wait_cnt >= ack_delay) begin
            core_ack <= 1'b1;
        end else begin
            wait_cnt <= irq_offer.valid ? wait_cnt + 4'h1 : 4'h0;
        end
    end
endmodule : cip_core_model

// File: testbench.sv
`timescale 1ns/1ps
module testbench;
    import cip_pkg::*;
    // ****************************************
    // stimulus and comparisons
    // ****************************************
    typedef struct {
        logic [7:0] rot;
        logic [7:0] hv;
        logic [31:0] req;
        logic [7:0] vec;
        logic [2:0] kind;
    } cip_row_t;
    logic sys_clk, rst_n, reg_wr, reg_rd, guard_key_wr, instr_retire, global_ie;
    logic return_from_interrupt, boot_all, core_ack;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, guard_key, last_vec, n_taken, n0;
    logic [31:0] irq_req;
    logic [15:0] boot_end, reset_pc, last_addr;
    logic [2:0] last_kind;
    logic [3:0] ack_delay;
    cip_offer_t irq_offer;
    int n_errors = 0;
    int checks = 0;
    // rotation, high vector, requests, expected vector and level
    cip_row_t rows [8] = '{'{8'h00, 8'h00, 32'h220, 8'h05, 3'b001},
        '{8'h05, 8'h00, 32'h220, 8'h09, 3'b001}, '{8'h1e, 8'h00, 32'h80000008, 8'h1f, 3'b001},
        '{8'h0a, 8'h00, 32'h204, 8'h02, 3'b001}, '{8'h1f, 8'h00, 32'h80000010, 8'h04, 3'b001},
        '{8'h00, 8'h07, 32'h88, 8'h07, 3'b010}, '{8'h00, 8'h00, 32'h88, 8'h03, 3'b001},
        '{8'h05, 8'h07, 32'h82, 8'h01, 3'b100}};
    logic [31:0] nreq [3] = '{32'h20, 32'ha0, 32'ha2};
    logic [7:0] nst [4] = '{8'h00, 8'h01, 8'h03, 8'h83};

    cip_core dut (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .guard_key_wr(guard_key_wr),
        .guard_key(guard_key), .instr_retire(instr_retire), .irq_req(irq_req),
        .global_ie(global_ie), .core_ack(core_ack), .return_from_interrupt(return_from_interrupt),
        .boot_end(boot_end), .boot_all(boot_all), .irq_offer(irq_offer), .reset_pc(reset_pc));
    cip_core_model model_i (.sys_clk(sys_clk), .rst_n(rst_n), .irq_offer(irq_offer),
        .ack_delay(ack_delay), .core_ack(core_ack), .n_taken(n_taken), .last_vec(last_vec),
        .last_kind(last_kind), .last_addr(last_addr));

    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic summarize;
        $display("checks %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : summarize
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : wr
    // data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [7:0] e, input string nm);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        chk(nm, 16'(e), 16'(reg_rdata));
    endtask : rd
    // key write, then retire pulses spaced so no strobe is set twice in one step
    task automatic unlock(input logic [7:0] key, input int n);
        @(posedge sys_clk);
        guard_key <= key;
        guard_key_wr <= 1'b1;
        @(posedge sys_clk);
        guard_key_wr <= 1'b0;
        repeat (n) begin
            instr_retire <= 1'b1;
            @(posedge sys_clk);
            instr_retire <= 1'b0;
            @(posedge sys_clk);
        end
    endtask : unlock
    task automatic take(input logic [31:0] req);
        n0 = n_taken;
        @(posedge sys_clk);
        irq_req <= req;
        for (int i = 0; i < 40 && n_taken == n0; i++) @(posedge sys_clk);
        if (n_taken != n0) begin
            #1;
        end else begin
            chk("accept wait", 16'h0001, 16'h0000);
            summarize();
        end
    endtask : take
    task automatic ret(input logic [31:0] req);
        @(posedge sys_clk);
        irq_req <= req;
        return_from_interrupt <= 1'b1;
        @(posedge sys_clk);
        return_from_interrupt <= 1'b0;
    endtask : ret

    initial begin
        {rst_n, reg_wr, reg_rd, guard_key_wr, instr_retire, return_from_interrupt} = 6'h00;
        {reg_addr, reg_wdata, guard_key, irq_req, boot_all, ack_delay} = '0;
        boot_end = 16'h0100;
        global_ie = 1'b1;
        repeat (20) @(posedge sys_clk);
        rst_n <= 1'b1;
        for (int a = 0; a < 5; a++) rd(8'(a), 8'h00, "reset value");
        chk("reset pc", 16'h0000, reset_pc);
        $display("test reset done");
        foreach (rows[i]) begin
            wr(8'h02, rows[i].rot);
            wr(8'h03, rows[i].hv);
            take(rows[i].req);
            chk("vector", 16'(rows[i].vec), 16'(last_vec));
            chk("level", 16'(rows[i].kind), 16'(last_kind));
            chk("address", 16'h0100 + {7'h00, rows[i].vec, 1'b0}, last_addr);
            ret(32'h0);
        end
        $display("test arbitration table done");
        wr(8'h00, 8'hff);
        rd(8'h00, 8'h01, "control no key");
        wr(8'h01, 8'hff);
        rd(8'h01, 8'h00, "status write");
        unlock(8'h11, 0);
        wr(8'h00, 8'h60);
        rd(8'h00, 8'h00, "wrong key");
        unlock(8'h5a, 3);
        wr(8'h00, 8'h60);
        rd(8'h00, 8'h60, "unlocked write");
        for (int k = 0; k < 3; k++) begin
            take(nreq[k]);
            chk("compact vector", 16'(3 - k), 16'(last_vec));
            chk("compact address", 16'(6 - 2 * k), last_addr);
            ret(32'h0);
        end
        unlock(8'h5a, 4);
        wr(8'h00, 8'h00);
        rd(8'h00, 8'h60, "late write");
        unlock(8'h5a, 0);
        wr(8'h00, 8'h00);
        rd(8'h00, 8'h00, "location cleared");
        boot_all <= 1'b1;
        take(32'h20);
        chk("whole boot address", 16'h000a, last_addr);
        ret(32'h0);
        boot_all <= 1'b0;
        $display("test protection done");
        ack_delay <= 4'h3;
        wr(8'h00, 8'h01);
        wr(8'h02, 8'h00);
        for (int k = 0; k < 3; k++) begin
            take(32'h50);
            chk("round robin", k == 1 ? 16'h0006 : 16'h0004, 16'(last_vec));
            rd(8'h02, k == 1 ? 8'h06 : 8'h04, "rotation update");
            ret(k == 2 ? 32'h0 : 32'h50);
        end
        ack_delay <= 4'h0;
        wr(8'h00, 8'h00);
        $display("test round robin done");
        for (int k = 0; k < 3; k++) begin
            take(nreq[k]);
            rd(8'h01, nst[k + 1], "level entry");
        end
        n0 = n_taken;
        repeat (10) @(posedge sys_clk);
        chk("nonmaskable kept", 16'(n0), 16'(n_taken));
        for (int k = 2; k >= 0; k--) begin
            ret(k > 0 ? nreq[k - 1] : 32'h0);
            rd(8'h01, nst[k], "level return");
        end
        global_ie <= 1'b0;
        take(32'h22);
        chk("masked nonmaskable", 16'h0001, 16'(last_vec));
        rd(8'h01, 8'h80, "nonmaskable flag");
        ret(32'h20);
        n0 = n_taken;
        repeat (10) @(posedge sys_clk);
        chk("masked normal", 16'(n0), 16'(n_taken));
        $display("test nesting done");
        summarize();
    end
endmodule : testbench
